/* rtl/wpsa_pkg.sv */
// shared constants for the weld panel start and alarm controller
package wpsa_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int REPEAT_MS = 250;
  localparam int HOLD_MS = 4000;
  localparam int RESTART_MS = 20;
  localparam int DEBOUNCE_MS = 10;
  localparam int REPEAT_TICKS = REPEAT_MS / TICK_MS;
  localparam int HOLD_TICKS = HOLD_MS / TICK_MS;
  localparam int RESTART_TICKS = (RESTART_MS + TICK_MS - 1) / TICK_MS;
  localparam int DEBOUNCE_TICKS = DEBOUNCE_MS / TICK_MS;
  localparam logic [6:0] AMP_STEP_FINE = 7'h01;
  localparam logic [6:0] AMP_STEP_COARSE = 7'h05;
  localparam logic [6:0] AMP_MAX = 7'h64;
  localparam logic [6:0] AMP_MIN = 7'h00;
  localparam logic [9:0] REG_FIRST = 10'h065;
  localparam logic [9:0] REG_LAST = 10'h071;
  localparam logic LATCH_RESET = 1'b0;
  localparam logic ANALOG_RESET = 1'b0;
  typedef enum logic [1:0] {WPSA_AMP, WPSA_REG_SEL, WPSA_REG_VAL} wpsa_disp_t;
endpackage : wpsa_pkg

/* rtl/wpsa_key_filter.sv */
// key synchroniser and debouncer with press pulse
`timescale 1ns/1ps
module wpsa_key_filter #(
  parameter int STABLE_TICKS = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic key_raw,
  output logic key_level,
  output logic key_press
);
  logic s1_q, s2_q, s3_q;
  logic [15:0] cnt_q;
  // three stages; second and third must agree before a change is seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= key_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
      key_level <= 1'b0;
      key_press <= 1'b0;
    end else begin
      key_press <= 1'b0;
      if (s2_q != s3_q || s3_q == key_level) begin
        cnt_q <= 16'h0000;
      end else if (tick) begin
        if (cnt_q >= 16'(STABLE_TICKS - 1)) begin
          key_level <= s3_q;
          key_press <= s3_q;
          cnt_q <= 16'h0000;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule : wpsa_key_filter

/* rtl/wpsa_ctrl.sv */
// front panel, start gating and alarm control for the weld generator
// What this block does
// - ultrasonics turn on when the remote run input asserts
// - ultrasonics stay on while run is held, stop when it drops
// - amplitude setpoint restored from non-volatile store after power-up
// - each up or down press changes amplitude by one percent
// - held key repeats one percent step every quarter second
// - after four seconds held, repeat step becomes five percent
// - analog source enabled: keys leave setpoint unchanged, show three dashes in amplitude view
// - amplitude comes from the selected one of two analog inputs
// - overload shows alarm icon, asserts summary alarm, holds till cleared as set by the latching option
// - latching mode clears only by reset key or remote clear
// - non-latching mode clears on run drop then reassert
// - no restart earlier than twenty milliseconds after an alarm
// - browse mode shows number icon; first entry register 101, else last
// - keys step register index; configuration key shows value with circle icon
// - latching option one bit, one latching, resets to zero
// - analog source option one bit, one enabled, resets to zero
`timescale 1ns/1ps
module wpsa_ctrl #(
  parameter int TICK_CYC = wpsa_pkg::TICK_CYC,
  parameter int REPEAT_TICKS = wpsa_pkg::REPEAT_TICKS,
  parameter int HOLD_TICKS = wpsa_pkg::HOLD_TICKS,
  parameter int RESTART_TICKS = wpsa_pkg::RESTART_TICKS,
  parameter int DEBOUNCE_TICKS = wpsa_pkg::DEBOUNCE_TICKS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic overload_in,
  input wire logic key_cfg,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_reset,
  input wire logic [6:0] nv_amp,
  input wire logic [6:0] analog_a,
  input wire logic [6:0] analog_b,
  input wire logic analog_sel_b,
  input wire logic latch_set,
  input wire logic analog_set,
  input wire logic [9:0] reg_value,
  output logic ready,
  output logic sonics_on,
  output logic alarm_out,
  output logic icon_alarm,
  output logic icon_percent,
  output logic icon_number,
  output logic icon_circle,
  output logic show_dashes,
  output logic [6:0] amp_setpoint,
  output logic [6:0] amp_active,
  output logic nv_write,
  output logic [9:0] reg_index,
  output logic [9:0] disp_value,
  output logic latch_mode,
  output logic analog_mode
);
  logic [16:0] pre_q;
  logic tick_q;
  logic run_s1_q, run_s2_q, run_s3_q, run_q;
  logic clr_s1_q, clr_s2_q, clr_s3_q;
  logic ovl_s1_q, ovl_s2_q, ovl_s3_q;
  logic up_lvl, up_prs, dn_lvl, dn_prs, cfg_prs, rst_prs;
  logic [12:0] hold_q;
  logic [8:0] rep_q;
  logic alarm_q, rearm_q, seen_drop_q;
  logic [7:0] gap_q;
  logic loaded_q;
  wpsa_pkg::wpsa_disp_t mode_q;
  logic [6:0] amp_q;
  logic [9:0] idx_q;
  logic [6:0] step;
  logic step_up, step_dn;

  // prescaled tick for every slow timer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_q <= 17'h00000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == 17'(TICK_CYC - 1));
      pre_q <= (pre_q == 17'(TICK_CYC - 1)) ? 17'h00000 : pre_q + 17'h00001;
    end
  end

  // pin synchronisers for run, clear and overload
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {run_s1_q, run_s2_q, run_s3_q, run_q} <= 4'h0;
      {clr_s1_q, clr_s2_q, clr_s3_q} <= 3'h0;
      {ovl_s1_q, ovl_s2_q, ovl_s3_q} <= 3'h0;
    end else begin
      run_s1_q <= run_in;
      run_s2_q <= run_s1_q;
      run_s3_q <= run_s2_q;
      if (run_s2_q == run_s3_q) run_q <= run_s3_q;
      clr_s1_q <= clear_in;
      clr_s2_q <= clr_s1_q;
      clr_s3_q <= clr_s2_q;
      ovl_s1_q <= overload_in;
      ovl_s2_q <= ovl_s1_q;
      ovl_s3_q <= ovl_s2_q;
    end
  end
  wire clr_ok = clr_s2_q & clr_s3_q;
  wire ovl_ok = ovl_s2_q & ovl_s3_q;

  wpsa_key_filter #(.STABLE_TICKS(DEBOUNCE_TICKS)) u_up (.clock(clock), .rst(rst),
    .tick(tick_q), .key_raw(key_up), .key_level(up_lvl), .key_press(up_prs));
  wpsa_key_filter #(.STABLE_TICKS(DEBOUNCE_TICKS)) u_dn (.clock(clock), .rst(rst),
    .tick(tick_q), .key_raw(key_down), .key_level(dn_lvl), .key_press(dn_prs));
  wpsa_key_filter #(.STABLE_TICKS(DEBOUNCE_TICKS)) u_cfg (.clock(clock), .rst(rst),
    .tick(tick_q), .key_raw(key_cfg), .key_level(), .key_press(cfg_prs));
  wpsa_key_filter #(.STABLE_TICKS(DEBOUNCE_TICKS)) u_rst (.clock(clock), .rst(rst),
    .tick(tick_q), .key_raw(key_reset), .key_level(), .key_press(rst_prs));

  // option bits: plain configuration inputs held in flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_mode <= wpsa_pkg::LATCH_RESET;
      analog_mode <= wpsa_pkg::ANALOG_RESET;
    end else begin
      latch_mode <= latch_set;
      analog_mode <= analog_set;
    end
  end

  // alarm: set wins over any clear in the same cycle
  logic run_prev_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_q <= 1'b0;
      seen_drop_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run_q;
      if (ovl_ok) begin
        alarm_q <= 1'b1;
        seen_drop_q <= 1'b0;
      end else if (alarm_q) begin
        if (latch_mode) begin
          if (rst_prs | clr_ok) alarm_q <= 1'b0;
        end else begin
          if (!run_q) seen_drop_q <= 1'b1;
          if (seen_drop_q && run_q && !run_prev_q) alarm_q <= 1'b0;
        end
      end
    end
  end

  // restart hold-off counts from the alarm's clearing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q <= 8'h00;
    end else if (alarm_q) begin
      gap_q <= 8'(RESTART_TICKS);
    end else if (tick_q && gap_q != 8'h00) begin
      gap_q <= gap_q - 8'h01;
    end
  end
  // a run held through the hold-off must be reapplied before sonics start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rearm_q <= 1'b0;
      sonics_on <= 1'b0;
    end else begin
      if (alarm_q || gap_q != 8'h00) rearm_q <= 1'b0;
      else if (!run_q) rearm_q <= 1'b1;
      sonics_on <= run_q & ready & (rearm_q | sonics_on);
    end
  end
  assign ready = ~alarm_q & (gap_q == 8'h00) & loaded_q;
  assign alarm_out = alarm_q;
  assign icon_alarm = alarm_q;

  // hold and repeat timers for the direction keys
  wire key_held = up_lvl ^ dn_lvl;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_q <= 13'h0000;
      rep_q <= 9'h000;
    end else if (!key_held) begin
      hold_q <= 13'h0000;
      rep_q <= 9'h000;
    end else if (tick_q) begin
      if (hold_q != 13'(HOLD_TICKS)) hold_q <= hold_q + 13'h0001;
      rep_q <= (rep_q == 9'(REPEAT_TICKS - 1)) ? 9'h000 : rep_q + 9'h001;
    end
  end
  wire rep_fire = key_held & tick_q & (rep_q == 9'(REPEAT_TICKS - 1));
  assign step = (hold_q == 13'(HOLD_TICKS)) ? wpsa_pkg::AMP_STEP_COARSE
                                              : wpsa_pkg::AMP_STEP_FINE;
  assign step_up = up_prs | (rep_fire & up_lvl);
  assign step_dn = dn_prs | (rep_fire & dn_lvl);

  // display mode walk on each configuration press
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= wpsa_pkg::WPSA_AMP;
    end else if (cfg_prs) begin
      case (mode_q)
        wpsa_pkg::WPSA_AMP: mode_q <= wpsa_pkg::WPSA_REG_SEL;
        wpsa_pkg::WPSA_REG_SEL: mode_q <= wpsa_pkg::WPSA_REG_VAL;
        wpsa_pkg::WPSA_REG_VAL: mode_q <= wpsa_pkg::WPSA_AMP;
        default: mode_q <= wpsa_pkg::WPSA_AMP;
      endcase
    end
  end

  // setpoint: loaded from store once, clamped 0..100, saved on every step, even one held at a limit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      amp_q <= wpsa_pkg::AMP_MIN;
      loaded_q <= 1'b0;
      nv_write <= 1'b0;
    end else begin
      nv_write <= 1'b0;
      if (!loaded_q) begin
        amp_q <= (nv_amp > wpsa_pkg::AMP_MAX) ? wpsa_pkg::AMP_MAX : nv_amp;
        loaded_q <= 1'b1;
      end else if (mode_q == wpsa_pkg::WPSA_AMP && !analog_mode) begin
        if (step_up) begin
          amp_q <= (amp_q > wpsa_pkg::AMP_MAX - step) ? wpsa_pkg::AMP_MAX : amp_q + step;
          nv_write <= 1'b1;
        end else if (step_dn) begin
          amp_q <= (amp_q < step) ? wpsa_pkg::AMP_MIN : amp_q - step;
          nv_write <= 1'b1;
        end
      end
    end
  end

  // register index survives leaving browse mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idx_q <= wpsa_pkg::REG_FIRST;
    end else if (mode_q == wpsa_pkg::WPSA_REG_SEL) begin
      if (step_up && idx_q != wpsa_pkg::REG_LAST) idx_q <= idx_q + 10'h001;
      else if (step_dn && idx_q != wpsa_pkg::REG_FIRST) idx_q <= idx_q - 10'h001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      amp_active <= wpsa_pkg::AMP_MIN;
      disp_value <= 10'h000;
    end else begin
      amp_active <= analog_mode ? (analog_sel_b ? analog_b : analog_a) : amp_q;
      case (mode_q)
        wpsa_pkg::WPSA_REG_SEL: disp_value <= idx_q;
        wpsa_pkg::WPSA_REG_VAL: disp_value <= reg_value;
        default: disp_value <= {3'h0, amp_q};
      endcase
    end
  end
  assign amp_setpoint = amp_q;
  assign reg_index = idx_q;
  assign icon_percent = (mode_q == wpsa_pkg::WPSA_AMP);
  assign icon_number = (mode_q == wpsa_pkg::WPSA_REG_SEL);
  assign icon_circle = (mode_q == wpsa_pkg::WPSA_REG_VAL);
  assign show_dashes = analog_mode & (mode_q == wpsa_pkg::WPSA_AMP);

  property p_alarm_holds;
    @(posedge clock) disable iff (rst)
      alarm_q && !rst_prs && !clr_ok && latch_mode |=> alarm_q;
  endproperty
  a_alarm_holds: assert property (p_alarm_holds) else $error("latched alarm dropped");
  property p_ovl_sets;
    @(posedge clock) disable iff (rst) ovl_ok |=> alarm_out && icon_alarm;
  endproperty
  a_ovl_sets: assert property (p_ovl_sets) else $error("overload not flagged");
  property p_no_sonics_alarm;
    @(posedge clock) disable iff (rst) alarm_q |=> ##1 !sonics_on;
  endproperty
  a_no_sonics_alarm: assert property (p_no_sonics_alarm) else $error("sonics in alarm");
  property p_run_drop;
    @(posedge clock) disable iff (rst) !run_q |=> !sonics_on;
  endproperty
  a_run_drop: assert property (p_run_drop) else $error("sonics without run");
  property p_gap_blocks;
    @(posedge clock) disable iff (rst) gap_q != 8'h00 |=> !sonics_on;
  endproperty
  a_gap_blocks: assert property (p_gap_blocks) else $error("restart within hold-off");
  property p_analog_freeze;
    @(posedge clock) disable iff (rst) loaded_q && analog_mode |=> $stable(amp_setpoint);
  endproperty
  a_analog_freeze: assert property (p_analog_freeze) else $error("keys moved setpoint");
  property p_amp_range;
    @(posedge clock) disable iff (rst) amp_setpoint <= wpsa_pkg::AMP_MAX;
  endproperty
  a_amp_range: assert property (p_amp_range) else $error("setpoint above 100");
  property p_fine_step;
    @(posedge clock) disable iff (rst)
      loaded_q && up_prs && icon_percent && !analog_mode && amp_q < 7'h63
        |=> amp_q == $past(amp_q) + 7'h01;
  endproperty
  a_fine_step: assert property (p_fine_step) else $error("press step not one");
  property p_one_icon;
    @(posedge clock) disable iff (rst) $onehot({icon_percent, icon_number, icon_circle});
  endproperty
  a_one_icon: assert property (p_one_icon) else $error("icons not exclusive");
endmodule : wpsa_ctrl

/* verification/wpsa_automation.sv */
// customer automation model driving the run and clear lines
`timescale 1ns/1ps
module wpsa_automation (
  input wire logic clock,
  input wire logic rst,
  input wire logic ready,
  input wire logic alarm,
  input wire logic want_run,
  input wire logic want_clear,
  output logic run_in,
  output logic clear_in
);
  // raise run only while ready (this covers the hold-off), or reapply it to clear an alarm
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_in <= 1'b0;
      clear_in <= 1'b0;
    end else begin
      run_in <= want_run && (run_in || ready || alarm);
      clear_in <= want_clear;
    end
  end
endmodule : wpsa_automation

/* verification/wpsa_ctrl_tb_top.sv */
// self-checking bench for the weld panel start and alarm controller
`timescale 1ns/1ps
module wpsa_ctrl_tb_top;
  localparam int TC = 4;
  localparam int HOLDOFF = 5;
  localparam logic [6:0] NV = 7'h0A;
  localparam logic [6:0] AN_A = 7'h21;
  localparam logic [6:0] AN_B = 7'h42;
  localparam logic [9:0] RV = 10'h2A5;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic want_run = 1'b0;
  logic want_clear = 1'b0;
  logic overload_in = 1'b0;
  logic [3:0] keys = 4'h0;
  logic latch_set = 1'b0;
  logic analog_set = 1'b0;
  logic analog_sel_b = 1'b0;
  logic run_in, clear_in, ready, sonics_on, alarm_out, icon_alarm, show_dashes, nv_write;
  logic icon_percent, icon_number, icon_circle, latch_mode, analog_mode;
  logic [6:0] amp_setpoint, amp_active;
  logic [9:0] reg_index, disp_value;
  int bad_count = 0;
  int comparisons = 0;
  int took;
  always #4 clock = ~clock;
  wpsa_automation auto_u (.clock, .rst, .ready, .alarm(alarm_out), .want_run, .want_clear,
    .run_in, .clear_in);
  // short timers keep the run small; expectations derive from these values
  wpsa_ctrl #(.TICK_CYC(TC), .REPEAT_TICKS(10), .HOLD_TICKS(20), .RESTART_TICKS(HOLDOFF),
    .DEBOUNCE_TICKS(2)) dut_u (.clock, .rst, .run_in, .clear_in, .overload_in,
    .key_cfg(keys[0]), .key_up(keys[1]), .key_down(keys[2]), .key_reset(keys[3]),
    .nv_amp(NV), .analog_a(AN_A), .analog_b(AN_B), .analog_sel_b, .latch_set, .analog_set,
    .reg_value(RV), .ready, .sonics_on, .alarm_out, .icon_alarm, .icon_percent, .icon_number,
    .icon_circle, .show_dashes, .amp_setpoint, .amp_active, .nv_write, .reg_index,
    .disp_value, .latch_mode, .analog_mode);
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {9'h000, exp}, {9'h000, got});
  endtask : chk_bit
  task automatic wait_for(input string what, ref logic sig, input logic lvl, input int lim,
      output int n);
    n = 0;
    while (sig !== lvl) begin
      @(negedge clock);
      n++;
      if (n > lim) begin
        chk_bit(what, lvl, sig);
        final_report();
      end
    end
  endtask : wait_for
  // a tap is released before the first repeat interval could elapse
  task automatic tap(input int k);
    @(posedge clock) keys[k] <= 1'b1;
    repeat (24) @(posedge clock);
    keys[k] <= 1'b0;
    repeat (24) @(posedge clock);
    @(negedge clock);
  endtask : tap
  task automatic pulse_overload();
    @(posedge clock) overload_in <= 1'b1;
    repeat (4) @(posedge clock);
    overload_in <= 1'b0;
    wait_for("alarm set", alarm_out, 1'b1, 12, took);
    // sonics drop one cycle after the alarm flop, so let that cycle pass
    @(negedge clock);
  endtask : pulse_overload
  task automatic hold_up();
    logic [6:0] prev;
    int fine;
    int last;
    int changes;
    int writes;
    prev = amp_setpoint;
    fine = 0;
    last = 0;
    changes = 0;
    writes = 0;
    @(posedge clock) keys[1] <= 1'b1;
    repeat (300) begin
      @(negedge clock);
      if (nv_write === 1'b1) writes++;
      if (amp_setpoint !== prev) begin
        changes++;
        last = int'(amp_setpoint) - int'(prev);
        if (last == 1) fine++;
        prev = amp_setpoint;
      end
    end
    @(posedge clock) keys[1] <= 1'b0;
    repeat (24) @(posedge clock);
    chk_bit("fine repeats", 1'b1, fine >= 2);
    chk("coarse step", 10'h005, 10'(last));
    chk("save pulses", 10'(changes), 10'(writes));
  endtask : hold_up
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wait_for("ready", ready, 1'b1, 20, took);
    chk("stored setpoint", {3'h0, NV}, {3'h0, amp_setpoint});
    chk_bit("percent icon", 1'b1, icon_percent);
    chk_bit("latch reset", 1'b0, latch_mode);
    chk_bit("analog reset", 1'b0, analog_mode);
    tap(1);
    chk("up step", {3'h0, NV + 7'h01}, {3'h0, amp_setpoint});
    tap(2);
    chk("down step", {3'h0, NV}, {3'h0, amp_setpoint});
    chk("shown setpoint", {3'h0, NV}, disp_value);
    chk("active setpoint", {3'h0, NV}, {3'h0, amp_active});
    chk_bit("no dashes", 1'b0, show_dashes);
    hold_up();
    tap(0);
    chk_bit("number icon", 1'b1, icon_number);
    chk("first index", 10'h065, reg_index);
    tap(1);
    chk("index step", 10'h066, reg_index);
    tap(0);
    chk_bit("circle icon", 1'b1, icon_circle);
    chk("shown value", RV, disp_value);
    tap(0);
    chk_bit("back to percent", 1'b1, icon_percent);
    tap(0);
    chk("last index", 10'h066, reg_index);
    tap(0);
    tap(0);
    @(posedge clock) analog_set <= 1'b1;
    repeat (4) @(negedge clock);
    chk_bit("analog mode", 1'b1, analog_mode);
    chk_bit("dashes", 1'b1, show_dashes);
    chk("analog a", {3'h0, AN_A}, {3'h0, amp_active});
    @(posedge clock) analog_sel_b <= 1'b1;
    repeat (4) @(negedge clock);
    chk("analog b", {3'h0, AN_B}, {3'h0, amp_active});
    took = int'(amp_setpoint);
    tap(1);
    chk("keys ignored", 10'(took), {3'h0, amp_setpoint});
    @(posedge clock) analog_set <= 1'b0;
    want_run <= 1'b1;
    wait_for("sonics on", sonics_on, 1'b1, 20, took);
    repeat (50) @(negedge clock);
    chk_bit("sonics held", 1'b1, sonics_on);
    @(posedge clock) want_run <= 1'b0;
    wait_for("sonics off", sonics_on, 1'b0, 10, took);
    @(posedge clock) want_run <= 1'b1;
    wait_for("sonics again", sonics_on, 1'b1, 20, took);
    pulse_overload();
    chk_bit("alarm icon", 1'b1, icon_alarm);
    chk_bit("sonics cut", 1'b0, sonics_on);
    repeat (30) @(negedge clock);
    chk_bit("alarm holds", 1'b1, alarm_out);
    @(posedge clock) want_run <= 1'b0;
    repeat (10) @(negedge clock);
    chk_bit("drop alone", 1'b1, alarm_out);
    @(posedge clock) want_run <= 1'b1;
    wait_for("run cycle clear", alarm_out, 1'b0, 12, took);
    chk_bit("no early restart", 1'b0, sonics_on);
    wait_for("ready after hold-off", ready, 1'b1, 100, took);
    chk_bit("hold-off length", 1'b1, took >= (HOLDOFF - 1) * TC);
    @(posedge clock) want_run <= 1'b0;
    repeat (10) @(posedge clock);
    want_run <= 1'b1;
    wait_for("restart", sonics_on, 1'b1, 20, took);
    @(posedge clock) latch_set <= 1'b1;
    repeat (4) @(negedge clock);
    chk_bit("latch mode", 1'b1, latch_mode);
    pulse_overload();
    @(posedge clock) want_run <= 1'b0;
    repeat (8) @(posedge clock);
    want_run <= 1'b1;
    repeat (12) @(negedge clock);
    chk_bit("latched", 1'b1, alarm_out);
    @(posedge clock) want_clear <= 1'b1;
    repeat (4) @(posedge clock);
    want_clear <= 1'b0;
    wait_for("remote clear", alarm_out, 1'b0, 12, took);
    pulse_overload();
    tap(3);
    chk_bit("reset key clear", 1'b0, alarm_out);
    final_report();
  end
endmodule : wpsa_ctrl_tb_top
